//--- logic/esl_blink.sv
// Square wave divider with equal on and off halves
`timescale 1ns/10ps
module esl_blink #(
  parameter int unsigned HALF_CYC = 125000000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Blink phase
  output logic      phase_o
);
  import esl_pkg::*;

  localparam int unsigned CW = $clog2(HALF_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } esl_blink_t;

  esl_blink_t s_reg;
  esl_blink_t s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt == CW'(HALF_CYC - 1)) begin // [R20]
      s_next.cnt   = '0;
      s_next.phase = ~s_reg.phase;
    end else begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign phase_o = s_reg.phase;
endmodule // esl_blink

//--- logic/esl_defines.svh
// Constants for the encoder status lamps and slave diagnosis block
`ifndef ESL_DEFINES_SVH
`define ESL_DEFINES_SVH

// Clock rate in kilohertz and lamp timing in milliseconds
`define ESL_CLK_KHZ          250000
`define ESL_HALF_1HZ_MS      500
`define ESL_HALF_10HZ_MS     50
`define ESL_FLICKER_MS       1000

// Register word indices on the bus
`define ESL_W_CTRL           10'h000
`define ESL_W_STAT           10'h001
`define ESL_W_MADDR          10'h002
`define ESL_W_XLEN           10'h003
`define ESL_W_BUF            10'h040

// Control register fields
`define ESL_CF_HWFAULT       0
`define ESL_CF_PRMFATAL      1
`define ESL_CF_PRMFIXED      2
`define ESL_CF_TEACH         3
`define ESL_CF_READY         4
`define ESL_CF_ADDRESSED     5
`define ESL_CF_CYCLIC        6
`define ESL_CF_DEVFAULT      7
`define ESL_CF_CLASS2        8
`define ESL_CF_EXTEN         9
`define ESL_CF_ADDR_LSB      16

// Station status bit positions
`define ESL_S1_PRMFAULT      6
`define ESL_S1_UNSUP         4
`define ESL_S1_EXTDIAG       3
`define ESL_S1_CFGFAULT      2
`define ESL_S1_NOTREADY      1
`define ESL_S2_SLAVE         2

// Diagnosis layout and limits
`define ESL_BYTE_ST1         8'h01
`define ESL_BYTE_ST2         8'h02
`define ESL_BYTE_ST3         8'h03
`define ESL_BYTE_MADDR       8'h04
`define ESL_BYTE_IDHI        8'h05
`define ESL_BYTE_IDLO        8'h06
`define ESL_BYTE_XLEN        8'h07
`define ESL_BYTE_EXT0        8'h08
`define ESL_DIAG_MAX         8'hf1
`define ESL_XLEN_C1          8'h09
`define ESL_XLEN_C2          8'h34
`define ESL_ADDR_MIN         8'h03
`define ESL_ADDR_MAX         8'h63
`define ESL_MADDR_NONE       8'hff

`endif

//--- logic/esl_diag_sel.sv
// Selects one byte of the diagnosis response by its number
`timescale 1ns/10ps
`include "esl_defines.svh"
module esl_diag_sel (
  // Byte number, one based
  input  wire logic [7:0]  idx_i,
  // Byte sources
  input  wire logic [7:0]  st1_i,
  input  wire logic [7:0]  st2_i,
  input  wire logic [7:0]  st3_i,
  input  wire logic [7:0]  maddr_i,
  input  wire logic [15:0] ident_i,
  input  wire logic [7:0]  xlen_i,
  input  wire logic [7:0]  ext_byte_i,
  // Selected byte
  output logic [7:0]       byte_o,
  output logic             in_range_o
);
  import esl_pkg::*;

  logic [8:0] last;

  always_comb begin
    last       = {1'b0, `ESL_BYTE_XLEN} + {1'b0, xlen_i};
    in_range_o = (idx_i != 8'h00) && ({1'b0, idx_i} <= last)
                 && (idx_i <= `ESL_DIAG_MAX); // [R10]
    case (idx_i) // [R9]
      `ESL_BYTE_ST1:   byte_o = st1_i;
      `ESL_BYTE_ST2:   byte_o = st2_i;
      `ESL_BYTE_ST3:   byte_o = st3_i;
      `ESL_BYTE_MADDR: byte_o = maddr_i;
      `ESL_BYTE_IDHI:  byte_o = ident_i[15:8];
      `ESL_BYTE_IDLO:  byte_o = ident_i[7:0];
      `ESL_BYTE_XLEN:  byte_o = xlen_i;
      default:         byte_o = in_range_o ? ext_byte_i : 8'h00; // [R10]
    endcase
  end
endmodule // esl_diag_sel

//--- logic/esl_pkg.sv
// Types shared by the lamp and diagnosis block
package esl_pkg;
  `include "esl_defines.svh"

  typedef enum logic [1:0] {
    ESL_LAMP_OFF,
    ESL_LAMP_SLOW,
    ESL_LAMP_FAST,
    ESL_LAMP_ON
  } esl_lamp_t;

  // Turns a lamp mode into a lamp level
  function automatic logic esl_lamp_level(input esl_lamp_t m,
                                          input logic      slow,
                                          input logic      fast);
    case (m)
      ESL_LAMP_OFF:  esl_lamp_level = 1'b0;
      ESL_LAMP_SLOW: esl_lamp_level = slow;
      ESL_LAMP_FAST: esl_lamp_level = fast;
      ESL_LAMP_ON:   esl_lamp_level = 1'b1;
      default:       esl_lamp_level = 1'b0;
    endcase
  endfunction
endpackage

//--- logic/esl_top.sv
// Status lamps and standard slave diagnosis of the encoder
// Operation
// [R1] Flicker both lamps at power-up, then follow state
// [R2] Status lamp dark: address outside 3-99, hardware fault
// [R3] Status lamp 10 Hz on irreparable setup error
// [R4] Status lamp 1 Hz: corrected error or teach-in
// [R5] Status lamp steady when ready, no error
// [R6] Fault lamp dark when fine and cyclic; code: dark when addressed, no device fault, ESL_CF_CYCLIC not read
// [R7] Fault lamp 1 Hz until master addresses device
// [R8] Fault lamp steady on irreparable device fault
// [R9] Response: status bytes, master, identifier, length
// [R10] Specific bytes from byte 8, 241 max
// [R11] Extended diagnosis class 1 or 2 chosen
// [R12] Status 1 bit 6: parameters rejected
// [R13] Status 1 bit 4: unsupported function requested
// [R14] Status 1 bit 3: extended diagnosis present
// [R15] Status 1 bit 2: configuration rejected
// [R16] Status 1 bit 1: not ready for exchange
// [R17] Master fills status 1 bits 7, 5, 0
// [R18] Master byte holds first valid parameterizer
// [R19] Status 2 bit 2 always one
// [R20] Blink rates divided from clock, equal halves
`timescale 1ns/10ps
`include "esl_defines.svh"
module esl_top #(
  parameter int unsigned HALF_1HZ_CYC  = `ESL_CLK_KHZ * `ESL_HALF_1HZ_MS,
  parameter int unsigned HALF_10HZ_CYC = `ESL_CLK_KHZ * `ESL_HALF_10HZ_MS,
  parameter int unsigned FLICKER_CYC   = `ESL_CLK_KHZ * `ESL_FLICKER_MS,
  parameter int unsigned EXT_DEPTH     = 52,
  // Identifier value is arbitrary
  parameter logic [15:0] IDENT         = 16'h5a5a
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:2] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Protocol events
  input  wire logic        prm_ok_i,
  input  wire logic [7:0]  prm_master_i,
  input  wire logic        prm_reject_i,
  input  wire logic        cfg_reject_i,
  input  wire logic        unsup_req_i,
  // Diagnosis byte port
  input  wire logic        diag_rd_i,
  input  wire logic [7:0]  diag_idx_i,
  output logic      [7:0]  diag_byte_o,
  output logic             diag_valid_o,
  output logic             diag_in_range_o,
  output logic      [7:0]  diag_len_o,
  // Lamps
  output logic             stat_lamp_o,
  output logic             bus_fault_lamp_o
);
  import esl_pkg::*;

  localparam int unsigned FCW = $clog2(FLICKER_CYC + 1);

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdat;
    logic [9:0]                flags;
    logic [7:0]                st_addr;
    logic                      prm_fault;
    logic                      cfg_fault;
    logic                      unsup;
    logic                      mlock;
    logic [7:0]                maddr;
    logic                      flick;
    logic [FCW-1:0]            fcnt;
    logic                      stat_lamp;
    logic                      bf_lamp;
    logic                      dvalid;
    logic                      drange;
    logic [7:0]                dbyte;
    logic [7:0]                dlen;
    logic [EXT_DEPTH-1:0][7:0] xbuf;
  } esl_state_t;

  esl_state_t s_reg;
  esl_state_t s_next;

  logic       slow;
  logic       fast;
  logic       req;
  logic       wr;
  logic       clr;
  logic       addr_bad;
  logic [7:0] xlen;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] st3;
  logic [9:0] bidx;
  logic [7:0] didx;
  logic [7:0] ext_byte;
  logic [7:0] sel_byte;
  logic       sel_range;
  esl_lamp_t  stat_mode;
  esl_lamp_t  bf_mode;

  esl_blink #(.HALF_CYC(HALF_1HZ_CYC)) u_slow (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .phase_o (slow)
  );

  esl_blink #(.HALF_CYC(HALF_10HZ_CYC)) u_fast (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .phase_o (fast)
  );

  esl_diag_sel u_sel (
    .idx_i      (diag_idx_i),
    .st1_i      (st1),
    .st2_i      (st2),
    .st3_i      (st3),
    .maddr_i    (s_reg.maddr),
    .ident_i    (IDENT),
    .xlen_i     (xlen),
    .ext_byte_i (ext_byte),
    .byte_o     (sel_byte),
    .in_range_o (sel_range)
  );

  // Status bytes and lamp modes from current state
  always_comb begin
    xlen = 8'h00;
    if (s_reg.flags[`ESL_CF_EXTEN]) begin // [R11]
      xlen = s_reg.flags[`ESL_CF_CLASS2] ? `ESL_XLEN_C2 : `ESL_XLEN_C1;
    end
    st1                   = 8'h00; // [R17]
    st1[`ESL_S1_PRMFAULT] = s_reg.prm_fault; // [R12]
    st1[`ESL_S1_UNSUP]    = s_reg.unsup; // [R13]
    st1[`ESL_S1_EXTDIAG]  = (xlen != 8'h00); // [R14]
    st1[`ESL_S1_CFGFAULT] = s_reg.cfg_fault; // [R15]
    st1[`ESL_S1_NOTREADY] = ~s_reg.flags[`ESL_CF_READY]; // [R16]
    st2                   = 8'h00;
    st2[`ESL_S2_SLAVE]    = 1'b1; // [R19]
    st3                   = 8'h00;
    didx     = diag_idx_i - `ESL_BYTE_EXT0;
    ext_byte = (diag_idx_i >= `ESL_BYTE_EXT0 && 32'(didx) < EXT_DEPTH)
               ? s_reg.xbuf[didx] : 8'h00; // [R10]
    addr_bad = (s_reg.st_addr < `ESL_ADDR_MIN) ||
               (s_reg.st_addr > `ESL_ADDR_MAX);
    if (addr_bad || s_reg.flags[`ESL_CF_HWFAULT]) begin // [R2]
      stat_mode = ESL_LAMP_OFF;
    end else if (s_reg.flags[`ESL_CF_PRMFATAL]) begin // [R3]
      stat_mode = ESL_LAMP_FAST;
    end else if (s_reg.flags[`ESL_CF_PRMFIXED] ||
                 s_reg.flags[`ESL_CF_TEACH]) begin // [R4]
      stat_mode = ESL_LAMP_SLOW;
    end else if (s_reg.flags[`ESL_CF_READY]) begin // [R5]
      stat_mode = ESL_LAMP_ON;
    end else begin
      stat_mode = ESL_LAMP_OFF;
    end
    if (s_reg.flags[`ESL_CF_DEVFAULT]) begin // [R8]
      bf_mode = ESL_LAMP_ON;
    end else if (!s_reg.flags[`ESL_CF_ADDRESSED]) begin // [R7]
      bf_mode = ESL_LAMP_SLOW;
    end else begin // [R6]
      bf_mode = ESL_LAMP_OFF;
    end
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    req    = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr     = req && wb_we_i;
    clr    = wr && (wb_adr_i == `ESL_W_STAT) && wb_sel_i[0];
    bidx   = wb_adr_i - `ESL_W_BUF;
    s_next.ack = req;
    if (req) begin
      case (wb_adr_i)
        `ESL_W_CTRL:  s_next.rdat = {8'h00, s_reg.st_addr, 6'h00,
                                     s_reg.flags};
        `ESL_W_STAT:  s_next.rdat = {5'h00, s_reg.flick, s_reg.bf_lamp,
                                     s_reg.stat_lamp, st3, st2, st1};
        `ESL_W_MADDR: s_next.rdat = {23'h0, s_reg.mlock, s_reg.maddr};
        `ESL_W_XLEN:  s_next.rdat = {24'h0, xlen};
        default: begin
          if (wb_adr_i >= `ESL_W_BUF && 32'(bidx) < EXT_DEPTH) begin
            s_next.rdat = {24'h0, s_reg.xbuf[bidx]};
          end else begin
            s_next.rdat = 32'h0;
          end
        end
      endcase
    end
    if (wr && wb_adr_i == `ESL_W_CTRL) begin
      if (wb_sel_i[0]) begin
        s_next.flags[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        s_next.flags[9:8] = wb_dat_i[9:8];
      end
      if (wb_sel_i[2]) begin
        s_next.st_addr = wb_dat_i[`ESL_CF_ADDR_LSB +: 8];
      end
    end
    if (wr && wb_adr_i >= `ESL_W_BUF && 32'(bidx) < EXT_DEPTH &&
        wb_sel_i[0]) begin
      s_next.xbuf[bidx] = wb_dat_i[7:0];
    end
    // Sticky faults: write one clears, a new event wins
    if (clr && wb_dat_i[`ESL_S1_PRMFAULT]) begin
      s_next.prm_fault = 1'b0;
    end
    if (clr && wb_dat_i[`ESL_S1_UNSUP]) begin
      s_next.unsup = 1'b0;
    end
    if (clr && wb_dat_i[`ESL_S1_CFGFAULT]) begin
      s_next.cfg_fault = 1'b0;
    end
    if (prm_reject_i) begin // [R12]
      s_next.prm_fault = 1'b1;
    end
    if (unsup_req_i) begin // [R13]
      s_next.unsup = 1'b1;
    end
    if (cfg_reject_i) begin // [R15]
      s_next.cfg_fault = 1'b1;
    end
    if (wr && wb_adr_i == `ESL_W_MADDR) begin
      s_next.mlock = 1'b0;
      s_next.maddr = `ESL_MADDR_NONE;
    end
    if (prm_ok_i && !s_reg.mlock) begin // [R18]
      s_next.mlock = 1'b1;
      s_next.maddr = prm_master_i;
    end
    // Start-up flicker
    if (s_reg.flick) begin // [R1]
      if (s_reg.fcnt == FCW'(FLICKER_CYC - 1)) begin
        s_next.flick = 1'b0;
      end else begin
        s_next.fcnt = s_reg.fcnt + FCW'(1);
      end
      s_next.stat_lamp = fast;
      s_next.bf_lamp   = fast;
    end else begin // [R1]
      s_next.stat_lamp = esl_lamp_level(stat_mode, slow, fast);
      s_next.bf_lamp   = esl_lamp_level(bf_mode, slow, fast);
    end
    // Diagnosis byte port
    s_next.dvalid = diag_rd_i;
    if (diag_rd_i) begin // [R9]
      s_next.dbyte  = sel_byte;
      s_next.drange = sel_range;
    end
    s_next.dlen = `ESL_BYTE_XLEN + xlen; // [R10]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg       <= '0;
      s_reg.maddr <= `ESL_MADDR_NONE;
      s_reg.flick <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o         = s_reg.ack;
  assign wb_dat_o         = s_reg.rdat;
  assign diag_byte_o      = s_reg.dbyte;
  assign diag_valid_o     = s_reg.dvalid;
  assign diag_in_range_o  = s_reg.drange;
  assign diag_len_o       = s_reg.dlen;
  assign stat_lamp_o      = s_reg.stat_lamp;
  assign bus_fault_lamp_o = s_reg.bf_lamp;

  // Checks
  AST_FLICK: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    s_reg.flick |=> stat_lamp_o == bus_fault_lamp_o)
    else $error("lamps differ during start-up flicker");
  AST_ADDR_DARK: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_reg.flick && addr_bad |=> !stat_lamp_o) // [R2]
    else $error("status lamp lit with bad address");
  AST_READY_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_reg.flick && stat_mode == ESL_LAMP_ON |=> stat_lamp_o) // [R5]
    else $error("status lamp not steady when ready");
  AST_FAST: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    !s_reg.flick && !addr_bad && !s_reg.flags[`ESL_CF_HWFAULT] &&
    s_reg.flags[`ESL_CF_PRMFATAL] |=> stat_lamp_o == $past(fast))
    else $error("status lamp not at fast blink");
  AST_BF_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_reg.flick && s_reg.flags[`ESL_CF_DEVFAULT] |=> bus_fault_lamp_o)
    else $error("fault lamp not lit on device fault"); // [R8]
  AST_BF_DARK: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_reg.flick && bf_mode == ESL_LAMP_OFF |=> !bus_fault_lamp_o)
    else $error("fault lamp lit while running"); // [R6]
  AST_PRM: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    prm_reject_i |=> st1[`ESL_S1_PRMFAULT])
    else $error("parameter fault bit not set");
  AST_UNSUP: assert property (@(posedge clk_i) disable iff (rst_i)
    unsup_req_i |=> st1[`ESL_S1_UNSUP]) // [R13]
    else $error("not supported bit not set");
  AST_CFG: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    cfg_reject_i |=> st1[`ESL_S1_CFGFAULT])
    else $error("configuration fault bit not set");
  AST_EXT: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    1'b1 |=> (diag_len_o != `ESL_BYTE_XLEN) == $past(st1[`ESL_S1_EXTDIAG]))
    else $error("extended diagnosis bit disagrees with length");
  AST_MLOCK: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    s_reg.mlock && !wr |=> $stable(s_reg.maddr))
    else $error("master address changed after lock");
  AST_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    diag_len_o <= `ESL_DIAG_MAX)
    else $error("diagnosis longer than allowed");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule // esl_top

//--- tb/esl_dp_master.sv
// Bus master model: protocol event pulses and diagnosis polls
`timescale 1ns/10ps
module esl_dp_master (
  // Clock
  input  wire logic       clk_i,
  // Diagnosis answer
  input  wire logic [7:0] diag_byte_i,
  input  wire logic       diag_valid_i,
  // Requests to the slave
  output logic            prm_ok_o,
  output logic [7:0]      prm_master_o,
  output logic            prm_reject_o,
  output logic            cfg_reject_o,
  output logic            unsup_req_o,
  output logic            diag_rd_o,
  output logic [7:0]      diag_idx_o
);
  logic [7:0] host_st1;
  initial begin
    {unsup_req_o, cfg_reject_o, prm_reject_o, prm_ok_o} = 4'h0;
    diag_rd_o    = 1'b0;
    prm_master_o = 8'h00;
    diag_idx_o   = 8'h00;
    host_st1     = 8'h00;
  end
  // One-cycle pulse of {unsup, cfg reject, prm reject, prm ok}
  task automatic pulse(input logic [3:0] ev, input logic [7:0] madr);
    @(posedge clk_i);
    {unsup_req_o, cfg_reject_o, prm_reject_o, prm_ok_o} <= ev;
    prm_master_o <= madr;
    @(posedge clk_i);
    {unsup_req_o, cfg_reject_o, prm_reject_o, prm_ok_o} <= 4'h0;
    prm_master_o <= ~madr;
  endtask
  // Poll one byte, answer awaited for at most eight cycles
  task automatic poll(input logic [7:0] idx, output logic [7:0] b);
    b = 8'hxx;
    @(posedge clk_i);
    diag_rd_o  <= 1'b1;
    diag_idx_o <= idx;
    @(posedge clk_i);
    diag_rd_o  <= 1'b0;
    diag_idx_o <= ~idx;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_i);
      if (diag_valid_i === 1'b1) begin
        b = diag_byte_i;
        break;
      end
    end
    // Host view clears status 1 bits 7, 5 and 0 and keeps bits 6 and 4 to 1
    if (idx == 8'h01)
      host_st1 = {1'b0, b[6], 1'b0, b[4:1], 1'b0};
  endtask
endmodule // esl_dp_master

//--- tb/esl_top_test.sv
// Self-checking bench for the status lamps and slave diagnosis block
`timescale 1ns/10ps
module esl_top_test;
  import esl_pkg::*;
  localparam int W = 40;
  localparam int H1 = 20;
  localparam int H10 = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:2] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        prm_ok_i, prm_reject_i, cfg_reject_i, unsup_req_i, diag_rd_i;
  logic [7:0]  prm_master_i, diag_idx_i, diag_byte_o, diag_len_o;
  logic        diag_valid_o, diag_in_range_o, stat_lamp_o, bus_fault_lamp_o;
  int          err_total, comparisons, seed;
  logic [31:0] tab [10] = '{32'h0032_0070, 32'h0002_0070, 32'h0003_0070,
    32'h0063_0070, 32'h0064_0070, 32'h0032_0071, 32'h0032_0072,
    32'h0032_0034, 32'h0032_0018, 32'h0032_00f0};

  esl_top #(.HALF_1HZ_CYC(H1), .HALF_10HZ_CYC(H10), .FLICKER_CYC(50),
    .IDENT(16'h3c96)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prm_ok_i(prm_ok_i),
    .prm_master_i(prm_master_i), .prm_reject_i(prm_reject_i),
    .cfg_reject_i(cfg_reject_i), .unsup_req_i(unsup_req_i),
    .diag_rd_i(diag_rd_i), .diag_idx_i(diag_idx_i),
    .diag_byte_o(diag_byte_o), .diag_valid_o(diag_valid_o),
    .diag_in_range_o(diag_in_range_o), .diag_len_o(diag_len_o),
    .stat_lamp_o(stat_lamp_o), .bus_fault_lamp_o(bus_fault_lamp_o));
  esl_dp_master u_master (.clk_i(clk_i), .diag_byte_i(diag_byte_o),
    .diag_valid_i(diag_valid_o), .prm_ok_o(prm_ok_i),
    .prm_master_o(prm_master_i), .prm_reject_o(prm_reject_i),
    .cfg_reject_o(cfg_reject_i), .unsup_req_o(unsup_req_i),
    .diag_rd_o(diag_rd_i), .diag_idx_o(diag_idx_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Classic single cycle, held until ack is sampled high or sixteen cycles pass
  task automatic wb(input logic we, input logic [9:0] adr,
                    input logic [3:0] sel, input logic [31:0] wd,
                    output logic [31:0] rd);
    rd = 32'hxxxxxxxx;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) begin
        rd = wb_dat_o;
        break;
      end
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_dat_i <= ~wd;
  endtask
  function automatic esl_lamp_t stat_exp(input logic [31:0] c);
    if (c[23:16] < 8'h03 || c[23:16] > 8'h63 || c[0]) return ESL_LAMP_OFF;
    if (c[1]) return ESL_LAMP_FAST;
    if (c[2] || c[3]) return ESL_LAMP_SLOW;
    return c[4] ? ESL_LAMP_ON : ESL_LAMP_OFF;
  endfunction
  function automatic esl_lamp_t fault_exp(input logic [31:0] c);
    if (c[7]) return ESL_LAMP_ON;
    return c[5] ? ESL_LAMP_OFF : ESL_LAMP_SLOW;
  endfunction
  // Lit cycles in the upper byte, level changes in the lower
  function automatic logic [15:0] lamp_exp(input esl_lamp_t m);
    case (m)
      ESL_LAMP_ON:   return {8'(W), 8'h00};
      ESL_LAMP_SLOW: return {8'(W / 2), 8'(W / H1)};
      ESL_LAMP_FAST: return {8'(W / 2), 8'(W / H10)};
      default:       return 16'h0000;
    endcase
  endfunction
  task automatic lamp_meas(output logic [15:0] s, output logic [15:0] f);
    logic ps, pf;
    s = 16'h0000;
    f = 16'h0000;
    @(posedge clk_i);
    ps = stat_lamp_o;
    pf = bus_fault_lamp_o;
    repeat (W) begin
      @(posedge clk_i);
      s = s + {7'h00, stat_lamp_o, 7'h00, stat_lamp_o ^ ps};
      f = f + {7'h00, bus_fault_lamp_o, 7'h00, bus_fault_lamp_o ^ pf};
      ps = stat_lamp_o;
      pf = bus_fault_lamp_o;
    end
  endtask
  task automatic lamp_chk(input logic [31:0] ctl);
    logic [15:0] s, f;
    logic [31:0] r;
    wb(1'b1, 10'h000, 4'hf, ctl, r);
    repeat (2) @(posedge clk_i);
    lamp_meas(s, f);
    check(32'(s), 32'(lamp_exp(stat_exp(ctl))));
    check(32'(f), 32'(lamp_exp(fault_exp(ctl))));
  endtask
  task automatic diag_std(input logic [7:0] st1, input logic [7:0] ma,
                          input logic [7:0] xl);
    logic [7:0] b;
    logic [7:0] e [7];
    e = '{st1, 8'h04, 8'h00, ma, 8'h3c, 8'h96, xl};
    for (int i = 1; i <= 7; i++) begin
      u_master.poll(8'(i), b);
      check(32'(b), 32'(e[i-1]));
    end
    check(32'(diag_len_o), 32'(8'h07 + xl));
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  initial begin
    logic [15:0] s, f;
    logic [31:0] r;
    logic [7:0]  b, v;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    err_total = 0;
    comparisons = 0;
    seed = 70993;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    lamp_meas(s, f);
    check(32'(s), 32'(lamp_exp(ESL_LAMP_FAST)));
    check(32'(f), 32'(lamp_exp(ESL_LAMP_FAST)));
    $display("test flicker done");
    repeat (10) @(posedge clk_i);
    foreach (tab[i]) lamp_chk(tab[i]);
    repeat (6) lamp_chk({8'h00, 8'($random(seed)) & 8'h7f, 6'h00,
                         10'($random(seed))});
    $display("test lamps done");
    wb(1'b1, 10'h000, 4'hf, 32'h0032_0270, r);
    diag_std(8'h08, 8'hff, 8'h09);
    u_master.pulse(4'h1, 8'h05);
    u_master.pulse(4'h1, 8'h09);
    u_master.pulse(4'he, 8'h00);
    diag_std(8'h5c, 8'h05, 8'h09);
    wb(1'b0, 10'h002, 4'hf, 32'h0, r);
    check(r, 32'h0000_0105);
    wb(1'b1, 10'h000, 4'hf, 32'h0032_0060, r);
    diag_std(8'h56, 8'h05, 8'h00);
    wb(1'b1, 10'h001, 4'h1, 32'h0000_0054, r);
    wb(1'b1, 10'h002, 4'hf, 32'h0, r);
    u_master.pulse(4'h1, 8'h07);
    diag_std(8'h02, 8'h07, 8'h00);
    $display("test status done");
    wb(1'b1, 10'h000, 4'hf, 32'h0032_0370, r);
    v = 8'($random(seed));
    wb(1'b1, 10'h040, 4'h1, 32'(v), r);
    wb(1'b1, 10'h073, 4'h1, 32'(~v), r);
    u_master.poll(8'd8, b);
    check(32'(b), 32'(v));
    u_master.poll(8'd59, b);
    check(32'({diag_in_range_o, b}), 32'({1'b1, ~v}));
    u_master.poll(8'd60, b);
    check(32'({diag_in_range_o, b}), 32'h0);
    u_master.poll(8'd241, b);
    check(32'({diag_in_range_o, b}), 32'h0);
    diag_std(8'h08, 8'h07, 8'h34);
    wb(1'b0, 10'h3ff, 4'hf, 32'h0, r);
    check(r, 32'h0);
    $display("test diagnosis done");
    close_out();
  end
endmodule // esl_top_test
